//--- inc/cell_regs_pkg.sv
package cell_regs_pkg;
  // Register addresses in the 26-bit host space
  localparam logic [25:0] ADDR_IND_ADDR = 26'h0030810;
  localparam logic [25:0] ADDR_IND_DATA = 26'h0030814;
  localparam logic [25:0] ADDR_ESW_OVH_INFO1 = 26'h0030818;
  localparam logic [25:0] ADDR_RM_OVERLAY = 26'h003081c;
  localparam logic [25:0] ADDR_EGR_OVH_MANIP = 26'h0030820;
  localparam logic [25:0] ADDR_ING_PROC_CTRL = 26'h0030824;
  localparam logic [25:0] ADDR_EGR_PROC_CTRL = 26'h0030828;
  localparam logic [25:0] ADDR_CLP_OVERLAY = 26'h003082c;
  localparam logic [25:0] ADDR_COMMON_EXT_PTR = 26'h0030d88;
  localparam logic [25:0] ADDR_INT_STATUS = 26'h0030830;
  localparam logic [25:0] ADDR_INT_MASK = 26'h0030834;
  localparam logic [25:0] ADDR_CORE_REV = 26'h0030838;
  localparam logic [25:0] ADDR_DEVICE_REV = 26'h003083c;
  localparam logic [25:0] ADDR_ESW_IF_CONFIG = 26'h0030840;

  // Field positions
  localparam int QFULL_BIT = 21;
  localparam int CONG_BIT = 1;
  localparam int ABR_MARK_BIT = 0;
  localparam int EGR_ABR_BIT = 0;
  localparam int IND_BUSY_BIT = 31;
  localparam int IND_DIR_BIT = 30;
  localparam int IND_SIZE_BIT = 29;
  localparam int IND_SPACE_LSB = 24;
  localparam int IND_ADDR_LSB = 1;
  localparam int CONNID_SIZE_LSB = 0;
  localparam int TS_SIZE_LSB = 8;
  localparam int MBIT_SRC_LSB = 16;
  localparam int VPI_SEL_BIT = 0;
  localparam int CORE_MAJOR_LSB = 6;
  localparam int DEV_IDENT_LSB = 12;

  // Writable bits per register; all others read 0, except indirect address bit 31, which reads busy
  localparam logic [31:0] IND_ADDR_WMASK = 32'h63fffffe;
  localparam logic [31:0] EGR_MANIP_WMASK = 32'h00031f1f;
  localparam logic [31:0] ING_CTRL_WMASK = 32'h00000003;
  localparam logic [31:0] EGR_CTRL_WMASK = 32'h00000001;
  localparam logic [31:0] INT_MASK_WMASK = 32'h00200000;
  localparam logic [31:0] ESW_IF_WMASK = 32'h00000001;
  localparam logic [31:0] REG_RESET = 32'h00000000;

  // Revision codes; values are arbitrary
  localparam logic [5:0] CORE_MAJOR_REV = 6'h2a;
  localparam logic [5:0] CORE_MINOR_REV = 6'h15;
  localparam logic [19:0] DEVICE_IDENT = 20'h5a5a5;
  localparam logic [5:0] DEVICE_MAJOR_REV = 6'h2c;
  localparam logic [5:0] DEVICE_MINOR_REV = 6'h13;

  // M bit sources
  localparam logic [1:0] MSRC_EXTRACT = 2'h0;
  localparam logic [1:0] MSRC_INVERT = 2'h1;
  localparam logic [1:0] MSRC_ONE = 2'h2;
  localparam logic [1:0] MSRC_ZERO = 2'h3;

  // Monitoring cell queue and insertion bucket
  localparam int QUEUE_DEPTH = 4;
  localparam logic [2:0] QUEUE_FULL_COUNT = 3'h4;
  localparam logic [1:0] BUCKET_MAX_CREDIT = 2'h2;
  localparam int CLK_PERIOD_NS = 40;
  localparam int BUCKET_PERIOD_NS = 2720;
  localparam int BUCKET_PERIOD_CYC = (BUCKET_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [6:0] BUCKET_TICK_LAST = 7'(BUCKET_PERIOD_CYC - 1);

  typedef enum {IND_IDLE, IND_WAIT} ind_state_type;
endpackage

//--- verilog/mon_cell_queue.sv
`timescale 1ns/100ps
module mon_cell_queue (
  input wire logic clk_in, // System clock
  input wire logic rst_n_in, // Synchronous reset, active low
  input wire logic gen_in, // Monitoring cell generated, pulse
  input wire logic slot_in, // Insertion slot offered, pulse
  output logic insert_out, // Cell inserted this cycle, pulse
  output logic full_out // Queue holds its maximum
);
  logic [2:0] count_q;
  logic [1:0] credit_q;
  logic [6:0] tick_q;
  logic tick_w;
  logic push_w;
  logic pop_w;

  // Bucket refills one credit per period; a cell leaves only on a credit
  assign tick_w = (tick_q == cell_regs_pkg::BUCKET_TICK_LAST);
  assign push_w = gen_in && !full_out;
  assign pop_w = slot_in && (count_q != 3'h0) && (credit_q != 2'h0);
  assign full_out = (count_q == cell_regs_pkg::QUEUE_FULL_COUNT);
  assign insert_out = pop_w;

  // Period divider
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      tick_q <= 7'h00;
    end else begin
      tick_q <= tick_w ? 7'h00 : tick_q + 7'h01;
    end
  end

  // Credit: a refill and a spend in one cycle cancel
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      credit_q <= 2'h0;
    end else if (tick_w && !pop_w && credit_q != cell_regs_pkg::BUCKET_MAX_CREDIT) begin
      credit_q <= credit_q + 2'h1;
    end else if (pop_w && !tick_w) begin
      credit_q <= credit_q - 2'h1;
    end
  end

  // Occupancy; a cell offered while full is dropped, which is why full is flagged
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      count_q <= 3'h0;
    end else if (push_w && !pop_w) begin
      count_q <= count_q + 3'h1;
    end else if (pop_w && !push_w) begin
      count_q <= count_q - 3'h1;
    end
  end

  default clocking qcb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  bucket_gates_insert_a: assert property (insert_out && !tick_w
    |=> credit_q == $past(credit_q) - 2'h1)
    else $error("cell inserted without spending a credit");
  queue_never_over_a: assert property (full_out && gen_in && !pop_w |=> full_out)
    else $error("queue left full without insertion");
endmodule

//--- verilog/cell_proc_regs.sv
`timescale 1ns/100ps
module cell_proc_regs (
  input wire logic clk_in, // System clock, 25 MHz
  input wire logic rst_n_in, // Synchronous reset, active low
  input wire logic [25:0] host_addr_in, // Host register address
  input wire logic host_wr_in, // Host write strobe, pulse
  input wire logic host_rd_in, // Host read strobe, pulse
  input wire logic [31:0] host_wdata_in, // Host write data
  output logic [31:0] host_rdata_out, // Host read data
  output logic host_ack_out, // Access done, pulse
  output logic irq_out, // Interrupt, active high
  input wire logic fmc_gen_in, // Forward monitoring cell generated
  input wire logic fmc_slot_in, // Cell slot free for insertion
  output logic fmc_insert_out, // Forward monitoring cell inserted
  output logic mem_req_out, // Indirect memory request, level
  output logic mem_read_out, // Indirect direction, 1 read
  output logic mem_size16_out, // Indirect size, 1 is 16 bits
  output logic [1:0] mem_space_out, // Indirect address space
  output logic [22:0] mem_addr_out, // Indirect address bits 23:1
  output logic [31:0] mem_wdata_out, // Indirect write data
  input wire logic [31:0] mem_rdata_in, // Indirect read data
  input wire logic mem_done_in, // Indirect access finished, pulse
  input wire logic ing_cell_valid_in, // Ingress cell present
  input wire logic ing_cell_clp_in, // Ingress cell CLP
  input wire logic conn_marking_enable_in, // Per-connection marking enable
  input wire logic conn_abr_mark_in, // Per-connection ABR marking enable
  output logic ing_discard_out, // Discard this ingress cell
  output logic ing_abr_mark_out, // Mark this ingress cell
  output logic ingress_congestion_out, // Global congestion flag
  output logic egress_abr_mark_enable_out, // Global egress marking enable
  input wire logic egr_mbit_extracted_in, // M bit from cell overhead
  input wire logic [11:0] hdr_vpi_in, // VPI from cell header
  output logic egr_mbit_out, // Selected M bit
  output logic [11:0] egress_connection_id_out, // VPI part of header identifier
  output logic [4:0] egress_connid_size_out, // Identifier width
  output logic [4:0] egress_timestamp_size_out, // Timestamp width
  output logic [1:0] egress_mbit_source_out // M bit source
);
  logic [31:0] ind_addr_q;
  logic [31:0] ind_data_q;
  logic [31:0] esw_info_q;
  logic [31:0] rm_overlay_q;
  logic [31:0] egr_manip_q;
  logic [31:0] ing_ctrl_q;
  logic [31:0] egr_ctrl_q;
  logic [31:0] clp_overlay_q;
  logic [31:0] ext_ptr_q;
  logic [31:0] int_mask_q;
  logic [31:0] esw_if_q;
  logic mon_queue_full_q;
  logic qfull_prev_q;
  logic indirect_busy_q;
  logic [31:0] rdata_q;
  logic ack_q;
  logic mbit_q;
  logic [11:0] connid_q;
  logic discard_q;
  logic mark_q;
  cell_regs_pkg::ind_state_type state_q;
  cell_regs_pkg::ind_state_type state_d;
  logic qfull_w;
  logic qfull_rise_w;

  // Address decode
  wire sel_ind_addr = (host_addr_in == cell_regs_pkg::ADDR_IND_ADDR);
  wire sel_ind_data = (host_addr_in == cell_regs_pkg::ADDR_IND_DATA);
  wire sel_esw_info = (host_addr_in == cell_regs_pkg::ADDR_ESW_OVH_INFO1);
  wire sel_rm_ovl = (host_addr_in == cell_regs_pkg::ADDR_RM_OVERLAY);
  wire sel_egr_manip = (host_addr_in == cell_regs_pkg::ADDR_EGR_OVH_MANIP);
  wire sel_ing_ctrl = (host_addr_in == cell_regs_pkg::ADDR_ING_PROC_CTRL);
  wire sel_egr_ctrl = (host_addr_in == cell_regs_pkg::ADDR_EGR_PROC_CTRL);
  wire sel_clp_ovl = (host_addr_in == cell_regs_pkg::ADDR_CLP_OVERLAY);
  wire sel_ext_ptr = (host_addr_in == cell_regs_pkg::ADDR_COMMON_EXT_PTR);
  wire sel_int_stat = (host_addr_in == cell_regs_pkg::ADDR_INT_STATUS);
  wire sel_int_mask = (host_addr_in == cell_regs_pkg::ADDR_INT_MASK);
  wire sel_core_rev = (host_addr_in == cell_regs_pkg::ADDR_CORE_REV);
  wire sel_dev_rev = (host_addr_in == cell_regs_pkg::ADDR_DEVICE_REV);
  wire sel_esw_if = (host_addr_in == cell_regs_pkg::ADDR_ESW_IF_CONFIG);

  // Indirect registers are frozen while an access runs, so the engine sees stable operands
  wire ind_start_w = host_wr_in && sel_ind_addr && !indirect_busy_q;
  wire ind_data_wr_w = host_wr_in && sel_ind_data && !indirect_busy_q;
  wire ind_done_w = (state_q == cell_regs_pkg::IND_WAIT) && mem_done_in;
  wire ind_read_w = ind_addr_q[cell_regs_pkg::IND_DIR_BIT];
  wire stat_clear_w = host_wr_in && sel_int_stat && host_wdata_in[cell_regs_pkg::QFULL_BIT];

  // Fixed revision words
  wire [31:0] core_rev_w = {20'h00000, cell_regs_pkg::CORE_MAJOR_REV,
                            cell_regs_pkg::CORE_MINOR_REV};
  wire [31:0] dev_rev_w = {cell_regs_pkg::DEVICE_IDENT, cell_regs_pkg::DEVICE_MAJOR_REV,
                           cell_regs_pkg::DEVICE_MINOR_REV};
  wire [31:0] int_stat_w = {10'h000, mon_queue_full_q, 21'h000000};

  // Read mux; unmapped addresses return zero
  wire [31:0] read_mux_w =
    sel_ind_addr ? {indirect_busy_q, ind_addr_q[30:0]} :
    sel_ind_data ? ind_data_q :
    sel_esw_info ? esw_info_q :
    sel_rm_ovl ? rm_overlay_q :
    sel_egr_manip ? egr_manip_q :
    sel_ing_ctrl ? ing_ctrl_q :
    sel_egr_ctrl ? egr_ctrl_q :
    sel_clp_ovl ? clp_overlay_q :
    sel_ext_ptr ? ext_ptr_q :
    sel_int_stat ? int_stat_w :
    sel_int_mask ? int_mask_q :
    sel_core_rev ? core_rev_w :
    sel_dev_rev ? dev_rev_w :
    sel_esw_if ? esw_if_q : 32'h00000000;

  // Monitoring cell queue with its insertion bucket
  mon_cell_queue u_queue (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .gen_in(fmc_gen_in),
    .slot_in(fmc_slot_in),
    .insert_out(fmc_insert_out),
    .full_out(qfull_w)
  );

  assign qfull_rise_w = qfull_w && !qfull_prev_q;

  // Plain control registers; masks keep unused bits at zero
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      esw_info_q <= cell_regs_pkg::REG_RESET;
      rm_overlay_q <= cell_regs_pkg::REG_RESET;
      egr_manip_q <= cell_regs_pkg::REG_RESET;
      ing_ctrl_q <= cell_regs_pkg::REG_RESET;
      egr_ctrl_q <= cell_regs_pkg::REG_RESET;
      clp_overlay_q <= cell_regs_pkg::REG_RESET;
      ext_ptr_q <= cell_regs_pkg::REG_RESET;
      int_mask_q <= cell_regs_pkg::REG_RESET;
      esw_if_q <= cell_regs_pkg::REG_RESET;
    end else if (host_wr_in) begin
      if (sel_esw_info) esw_info_q <= host_wdata_in;
      if (sel_rm_ovl) rm_overlay_q <= host_wdata_in;
      if (sel_egr_manip) egr_manip_q <= host_wdata_in & cell_regs_pkg::EGR_MANIP_WMASK;
      if (sel_ing_ctrl) ing_ctrl_q <= host_wdata_in & cell_regs_pkg::ING_CTRL_WMASK;
      if (sel_egr_ctrl) egr_ctrl_q <= host_wdata_in & cell_regs_pkg::EGR_CTRL_WMASK;
      if (sel_clp_ovl) clp_overlay_q <= host_wdata_in;
      if (sel_ext_ptr) ext_ptr_q <= host_wdata_in;
      if (sel_int_mask) int_mask_q <= host_wdata_in & cell_regs_pkg::INT_MASK_WMASK;
      if (sel_esw_if) esw_if_q <= host_wdata_in & cell_regs_pkg::ESW_IF_WMASK;
    end
  end

  // Sticky queue-full flag; a new full event beats a clear in the same cycle
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      mon_queue_full_q <= 1'b0;
      qfull_prev_q <= 1'b0;
    end else begin
      qfull_prev_q <= qfull_w;
      if (qfull_rise_w) begin
        mon_queue_full_q <= 1'b1;
      end else if (stat_clear_w) begin
        mon_queue_full_q <= 1'b0;
      end
    end
  end

  // Interrupt only through the enable bit
  assign irq_out = mon_queue_full_q && int_mask_q[cell_regs_pkg::QFULL_BIT];

  // Indirect access sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      cell_regs_pkg::IND_IDLE: if (ind_start_w) state_d = cell_regs_pkg::IND_WAIT;
      cell_regs_pkg::IND_WAIT: if (mem_done_in) state_d = cell_regs_pkg::IND_IDLE;
      default: state_d = cell_regs_pkg::IND_IDLE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_q <= cell_regs_pkg::IND_IDLE;
      indirect_busy_q <= 1'b0;
      ind_addr_q <= cell_regs_pkg::REG_RESET;
    end else begin
      state_q <= state_d;
      if (ind_start_w) begin
        indirect_busy_q <= 1'b1;
        ind_addr_q <= host_wdata_in & cell_regs_pkg::IND_ADDR_WMASK;
      end else if (ind_done_w) begin
        indirect_busy_q <= 1'b0;
      end
    end
  end

  // Data register: host writes when idle, read results land on completion
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ind_data_q <= cell_regs_pkg::REG_RESET;
    end else if (ind_done_w && ind_read_w) begin
      ind_data_q <= mem_rdata_in;
    end else if (ind_data_wr_w) begin
      ind_data_q <= host_wdata_in;
    end
  end

  assign mem_req_out = (state_q == cell_regs_pkg::IND_WAIT);
  assign mem_read_out = ind_read_w;
  assign mem_size16_out = ind_addr_q[cell_regs_pkg::IND_SIZE_BIT];
  assign mem_space_out = ind_addr_q[cell_regs_pkg::IND_SPACE_LSB +: 2];
  assign mem_addr_out = ind_addr_q[cell_regs_pkg::IND_ADDR_LSB +: 23];
  assign mem_wdata_out = ind_data_q;

  // Host answer, one cycle after the strobe
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rdata_q <= 32'h00000000;
      ack_q <= 1'b0;
    end else begin
      ack_q <= host_wr_in || host_rd_in;
      if (host_rd_in) rdata_q <= read_mux_w;
    end
  end

  assign host_rdata_out = rdata_q;
  assign host_ack_out = ack_q;

  // Egress selection; registered so the cell path sees one stable cycle of latency
  wire [1:0] msrc_w = egr_manip_q[cell_regs_pkg::MBIT_SRC_LSB +: 2];
  wire vpi12_w = esw_if_q[cell_regs_pkg::VPI_SEL_BIT];
  wire mbit_sel_w = (msrc_w == cell_regs_pkg::MSRC_EXTRACT) ? egr_mbit_extracted_in :
                    (msrc_w == cell_regs_pkg::MSRC_INVERT) ? !egr_mbit_extracted_in :
                    (msrc_w == cell_regs_pkg::MSRC_ONE);
  wire [11:0] connid_w = vpi12_w ? hdr_vpi_in : {4'h0, hdr_vpi_in[7:0]};

  // Ingress decisions
  wire cong_w = ing_ctrl_q[cell_regs_pkg::CONG_BIT];
  wire abr_en_w = ing_ctrl_q[cell_regs_pkg::ABR_MARK_BIT];
  wire discard_w = ing_cell_valid_in && cong_w && conn_marking_enable_in
                   && ing_cell_clp_in;
  wire mark_w = ing_cell_valid_in && abr_en_w && conn_abr_mark_in;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      mbit_q <= 1'b0;
      connid_q <= 12'h000;
      discard_q <= 1'b0;
      mark_q <= 1'b0;
    end else begin
      mbit_q <= mbit_sel_w;
      connid_q <= connid_w;
      discard_q <= discard_w;
      mark_q <= mark_w;
    end
  end

  assign egr_mbit_out = mbit_q;
  assign egress_connection_id_out = connid_q;
  assign ing_discard_out = discard_q;
  assign ing_abr_mark_out = mark_q;
  assign ingress_congestion_out = cong_w;
  assign egress_abr_mark_enable_out = egr_ctrl_q[cell_regs_pkg::EGR_ABR_BIT];
  assign egress_connid_size_out = egr_manip_q[cell_regs_pkg::CONNID_SIZE_LSB +: 5];
  assign egress_timestamp_size_out = egr_manip_q[cell_regs_pkg::TS_SIZE_LSB +: 5];
  assign egress_mbit_source_out = msrc_w;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence ind_start_s;
    host_wr_in && sel_ind_addr && !indirect_busy_q;
  endsequence
  sequence ind_finish_s;
    mem_req_out && mem_done_in;
  endsequence

  busy_on_start_a: assert property (ind_start_s |=> indirect_busy_q && mem_req_out)
    else $error("busy not raised after indirect start");
  busy_off_done_a: assert property (ind_finish_s |=> !indirect_busy_q && !mem_req_out)
    else $error("busy not cleared after indirect done");
  read_result_a: assert property (ind_finish_s and mem_read_out
    |=> ind_data_q == $past(mem_rdata_in))
    else $error("read data not captured");
  direction_a: assert property (ind_start_s
    |=> mem_read_out == $past(host_wdata_in[30]))
    else $error("direction bit not applied");
  qfull_sets_a: assert property ($rose(qfull_w) |=> mon_queue_full_q)
    else $error("queue full not flagged");
  irq_enabled_a: assert property ($rose(qfull_w) && int_mask_q[21] |=> irq_out)
    else $error("interrupt missing on enabled queue full");
  irq_masked_a: assert property (!int_mask_q[21] |-> !irq_out)
    else $error("interrupt while masked");
  cong_discard_a: assert property (ing_cell_valid_in && conn_marking_enable_in && ing_cell_clp_in
    |=> ing_discard_out == $past(ing_ctrl_q[1]))
    else $error("discard does not follow congestion");
  mark_gate_a: assert property (!ing_ctrl_q[0] ##1 !ing_ctrl_q[0] |-> !ing_abr_mark_out)
    else $error("marking while disabled");
  mbit_const_a: assert property (msrc_w == 2'h2 |=> egr_mbit_out)
    else $error("constant one M bit not selected");
  vpi_narrow_a: assert property (!vpi12_w |=> egress_connection_id_out[11:8] == 4'h0)
    else $error("8-bit VPI not narrowed");
  reserved_zero_a: assert property (host_rd_in && sel_ing_ctrl
    |=> host_ack_out && host_rdata_out[31:2] == 30'h0)
    else $error("reserved bits read nonzero");
endmodule

//--- sim/tb_top.sv
`timescale 1ns/100ps
`define CHK(g, e) chk(32'(g), 32'(e))
module tb_top;
  logic clk_in = 1'b0, rst_n_in = 1'b0, host_wr_in = 1'b0, host_rd_in = 1'b0;
  logic fmc_gen_in = 1'b0, fmc_slot_in = 1'b0, mem_done_in = 1'b0, ing_cell_valid_in = 1'b0;
  logic ing_cell_clp_in = 1'b0, conn_marking_enable_in = 1'b0, conn_abr_mark_in = 1'b0;
  logic egr_mbit_extracted_in = 1'b0;
  logic [25:0] host_addr_in = 26'h0;
  logic [31:0] host_wdata_in = 32'h0, mem_rdata_in = 32'h0, host_rdata_out, mem_wdata_out;
  logic [11:0] hdr_vpi_in = 12'h0, egress_connection_id_out;
  logic host_ack_out, irq_out, fmc_insert_out, mem_req_out, mem_read_out, mem_size16_out;
  logic ing_discard_out, ing_abr_mark_out, ingress_congestion_out, egress_abr_mark_enable_out;
  logic egr_mbit_out;
  logic [1:0] mem_space_out, egress_mbit_source_out;
  logic [22:0] mem_addr_out;
  logic [4:0] egress_connid_size_out, egress_timestamp_size_out;
  logic [31:0] seed = 32'h498a;
  int err_count = 0;
  int n_compared = 0;
  int cyc = 0;
  // Writable registers and the bits that keep what is written
  logic [25:0] ra [9] = '{cell_regs_pkg::ADDR_ESW_OVH_INFO1, cell_regs_pkg::ADDR_RM_OVERLAY,
    cell_regs_pkg::ADDR_CLP_OVERLAY, cell_regs_pkg::ADDR_COMMON_EXT_PTR,
    cell_regs_pkg::ADDR_EGR_OVH_MANIP, cell_regs_pkg::ADDR_ING_PROC_CTRL,
    cell_regs_pkg::ADDR_EGR_PROC_CTRL, cell_regs_pkg::ADDR_ESW_IF_CONFIG,
    cell_regs_pkg::ADDR_INT_MASK};
  logic [31:0] rm [9] = '{32'hffffffff, 32'hffffffff, 32'hffffffff, 32'hffffffff,
    cell_regs_pkg::EGR_MANIP_WMASK, cell_regs_pkg::ING_CTRL_WMASK,
    cell_regs_pkg::EGR_CTRL_WMASK, cell_regs_pkg::ESW_IF_WMASK, cell_regs_pkg::INT_MASK_WMASK};

  cell_proc_regs u_dut (.clk_in, .rst_n_in, .host_addr_in, .host_wr_in, .host_rd_in,
    .host_wdata_in, .host_rdata_out, .host_ack_out, .irq_out, .fmc_gen_in, .fmc_slot_in,
    .fmc_insert_out, .mem_req_out, .mem_read_out, .mem_size16_out, .mem_space_out,
    .mem_addr_out, .mem_wdata_out, .mem_rdata_in, .mem_done_in, .ing_cell_valid_in,
    .ing_cell_clp_in, .conn_marking_enable_in, .conn_abr_mark_in, .ing_discard_out,
    .ing_abr_mark_out, .ingress_congestion_out, .egress_abr_mark_enable_out,
    .egr_mbit_extracted_in, .hdr_vpi_in, .egr_mbit_out, .egress_connection_id_out,
    .egress_connid_size_out, .egress_timestamp_size_out, .egress_mbit_source_out);

  // Free running 25 MHz clock
  always #20 clk_in = ~clk_in;

  // Clean edges since reset release; tracks the insertion bucket phase
  always @(posedge clk_in) cyc <= rst_n_in ? cyc + 1 : 0;

  // Xorshift keeps the run repeatable from a fixed seed
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic mbit_exp(input logic [1:0] s, input logic m);
    return (s == 2'h0) ? m : (s == 2'h1) ? ~m : (s == 2'h2);
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Host strobes are launched 1 ns after an edge; ack and data land one edge later.
  // An idle edge before each access keeps a strobe from dropping and rising in one step.
  task automatic reg_wr(input logic [25:0] a, input logic [31:0] d);
    @(posedge clk_in);
    #1 host_addr_in = a;
    host_wdata_in = d;
    host_wr_in = 1'b1;
    @(posedge clk_in);
    #1 host_wr_in = 1'b0;
    `CHK(host_ack_out, 1'b1);
  endtask

  task automatic rd_chk(input logic [25:0] a, input logic [31:0] e);
    @(posedge clk_in);
    #1 host_addr_in = a;
    host_rd_in = 1'b1;
    @(posedge clk_in);
    #1 host_rd_in = 1'b0;
    `CHK(host_ack_out, 1'b1);
    `CHK(host_rdata_out, e);
  endtask

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Watchdog, far beyond the roughly 600 cycles the tests need
  initial begin
    #(40 * 5000);
    err_count++;
    tally_and_finish();
  end

  initial begin
    logic [31:0] v, w, wd;
    int t[$];
    repeat (3) @(posedge clk_in);
    #1 rst_n_in = 1'b1;
    for (int i = 0; i < 9; i++) begin
      rd_chk(ra[i], 32'h0);
      v = rnd();
      reg_wr(ra[i], v);
      rd_chk(ra[i], v & rm[i]);
    end
    reg_wr(cell_regs_pkg::ADDR_CORE_REV, 32'hffffffff);
    rd_chk(cell_regs_pkg::ADDR_CORE_REV, {20'h0, cell_regs_pkg::CORE_MAJOR_REV,
      cell_regs_pkg::CORE_MINOR_REV});
    rd_chk(cell_regs_pkg::ADDR_DEVICE_REV, {cell_regs_pkg::DEVICE_IDENT,
      cell_regs_pkg::DEVICE_MAJOR_REV, cell_regs_pkg::DEVICE_MINOR_REV});
    rd_chk(26'h0030844, 32'h0);
    $display("test register map done");
    // Indirect write then read; the data register must survive a write while busy
    for (int d = 0; d < 2; d++) begin
      v = rnd();
      wd = rnd();
      w = {1'b0, d[0], v[23], 3'h0, v[25:24], v[22:0], 1'b0};
      reg_wr(cell_regs_pkg::ADDR_IND_DATA, wd);
      reg_wr(cell_regs_pkg::ADDR_IND_ADDR, w);
      `CHK({mem_req_out, mem_read_out, mem_size16_out, mem_space_out, mem_addr_out},
        {1'b1, d[0], v[23], v[25:24], v[22:0]});
      if (d == 0) `CHK(mem_wdata_out, wd);
      rd_chk(cell_regs_pkg::ADDR_IND_ADDR, w | 32'h80000000);
      reg_wr(cell_regs_pkg::ADDR_IND_DATA, ~wd);
      mem_rdata_in = rnd();
      mem_done_in = 1'b1;
      @(posedge clk_in);
      #1 mem_done_in = 1'b0;
      `CHK(mem_req_out, 1'b0);
      rd_chk(cell_regs_pkg::ADDR_IND_ADDR, w);
      rd_chk(cell_regs_pkg::ADDR_IND_DATA, d ? mem_rdata_in : wd);
      mem_rdata_in = ~mem_rdata_in;
    end
    $display("test indirect access done");
    // Fill the queue with no slots offered, then drain it under bucket pacing
    reg_wr(cell_regs_pkg::ADDR_INT_MASK, 32'h0);
    fmc_gen_in = 1'b1;
    repeat (4) @(posedge clk_in);
    #1 fmc_gen_in = 1'b0;
    repeat (2) @(posedge clk_in);
    #1 rd_chk(cell_regs_pkg::ADDR_INT_STATUS, 32'h00200000);
    `CHK(irq_out, 1'b0);
    reg_wr(cell_regs_pkg::ADDR_INT_MASK, 32'h00200000);
    `CHK(irq_out, 1'b1);
    reg_wr(cell_regs_pkg::ADDR_INT_STATUS, 32'h00200000);
    `CHK(irq_out, 1'b0);
    repeat (140) @(posedge clk_in);
    // Start draining at a known bucket phase, so no refill lands in the first two slots
    #1 while (cyc % cell_regs_pkg::BUCKET_PERIOD_CYC != 10) begin
      @(posedge clk_in);
      #1;
    end
    fmc_slot_in = 1'b1;
    for (int c = 0; c < 200; c++) begin
      #1 if (fmc_insert_out === 1'b1) t.push_back(c);
      @(posedge clk_in);
      #1;
    end
    fmc_slot_in = 1'b0;
    `CHK(t.size(), 4);
    if (t.size() == 4) begin
      `CHK(t[1] - t[0], 1);
      `CHK(t[2], cell_regs_pkg::BUCKET_PERIOD_CYC - 10);
      `CHK(t[3] - t[2], cell_regs_pkg::BUCKET_PERIOD_CYC);
    end
    // Refill with the enable already set: the new full event raises the interrupt
    fmc_gen_in = 1'b1;
    repeat (4) @(posedge clk_in);
    #1 fmc_gen_in = 1'b0;
    @(posedge clk_in);
    #1 `CHK(irq_out, 1'b1);
    $display("test monitoring queue done");
    // Ingress and egress controls against random cells
    for (int i = 0; i < 12; i++) begin
      v = rnd();
      reg_wr(cell_regs_pkg::ADDR_ING_PROC_CTRL, {30'h0, v[1:0]});
      reg_wr(cell_regs_pkg::ADDR_EGR_PROC_CTRL, {31'h0, v[2]});
      reg_wr(cell_regs_pkg::ADDR_EGR_OVH_MANIP, {14'h0, v[4:3], 3'h0, v[9:5], 3'h0, v[14:10]});
      reg_wr(cell_regs_pkg::ADDR_ESW_IF_CONFIG, {31'h0, v[15]});
      {ing_cell_valid_in, ing_cell_clp_in, conn_marking_enable_in} = 3'h7 & (v[18:16] | 3'h4);
      {conn_abr_mark_in, egr_mbit_extracted_in, hdr_vpi_in} = v[31:18];
      @(posedge clk_in);
      #1 `CHK({ingress_congestion_out, ing_discard_out},
        {v[1], v[1] & v[17] & v[16]});
      `CHK({egress_abr_mark_enable_out, ing_abr_mark_out}, {v[2], v[0] & v[31]});
      `CHK(egress_connid_size_out, v[14:10]);
      `CHK(egress_timestamp_size_out, v[9:5]);
      `CHK({egress_mbit_source_out, egr_mbit_out}, {v[4:3], mbit_exp(v[4:3], v[30])});
      `CHK(egress_connection_id_out, v[15] ? v[29:18] : {4'h0, v[25:18]});
    end
    $display("test ingress and egress controls done");
    tally_and_finish();
  end
endmodule
